// ==== core/trigger_routing_matrix.sv ====
// Trigger routing crossbar with synchronous realignment and software pulse
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`include "trm_consts.svh"
`default_nettype none

module trigger_routing_matrix #(
  parameter int THR_W = `THR_W_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire trm_pkg::wb_req_t wb_i,
  output trm_pkg::wb_rsp_t wb_o,
  input wire logic pxi_clk10_i,
  input wire logic synth_clk_i,
  input wire logic front_clock_i,
  input wire logic [`N_FRONT-1:0] front_i,
  output logic [`N_FRONT-1:0] front_o,
  output logic [`N_FRONT-1:0] front_oe_o,
  input wire logic [`N_TRIG-1:0] trig_i,
  output logic [`N_TRIG-1:0] trig_o,
  output logic [`N_TRIG-1:0] trig_oe_o,
  input wire logic [`N_STAR-1:0] star_i,
  output logic [`N_STAR-1:0] star_o,
  output logic [`N_STAR-1:0] star_oe_o,
  output logic [`N_FRONT-1:0] term_en_o,
  output logic [`N_FRONT*THR_W-1:0] threshold_o
);
  import trm_pkg::*;

  localparam int NF = `N_FRONT;
  localparam int NT = `N_TRIG;
  localparam int ND = `N_DEST;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    base_sel_t fbase;
    base_sel_t tbase;
    logic [1:0] dsrc;
    logic [1:0][3:0] dexp;
    logic reject;
    logic [NF-1:0] term;
    logic [NF-1:0][THR_W-1:0] thr;
    route_cfg_t [ND-1:0] route;
    logic [ND-1:0] q;
    logic [ND-1:0] pend;
    logic [ND-1:0][3:0] cnt;
    logic [1:0][8:0] dcnt;
    logic [1:0] dprev;
    logic [1:0][3:0] cprev;
  } state_t;

  state_t s_q;
  state_t s_d;

  logic [1:0] base;
  logic [1:0] din;
  logic [1:0] dout;
  logic [1:0][3:0] clkv;
  logic [`SRC_W-1:0] srcv;
  logic [ND-1:0] edge_w;
  logic [ND-1:0] sv_w;
  logic [ND-1:0] dst;
  logic [ND-1:0] dst_oe;
  logic [31:0] rd;
  logic [31:0] wv;
  logic [31:0] bmask;
  logic [5:0] widx;

  // Synthesizer, PXI_CLK10 or front line 0 as base of a sync domain
  function automatic logic pick_base(base_sel_t b);
    case (b)
      BASE_SYNTH: pick_base = synth_clk_i;
      BASE_CLK10: pick_base = pxi_clk10_i;
      BASE_FRONT0: pick_base = front_i[0];
      default: pick_base = 1'b0;
    endcase
  endfunction

  // A route combination outside the matrix is refused at write time
  function automatic logic cfg_ok(logic [5:0] d, route_cfg_t c);
    cfg_ok = 1'b1;
    if (c.en) begin
      if (c.src > `SRC_FRONT_CLOCK_INPUT) begin
        cfg_ok = 1'b0;
      end
      if (c.src == `SRC_FRONT_CLOCK_INPUT && d < 6'(NF + NT)) begin
        cfg_ok = 1'b0;
      end
      if (!c.sync && (c.src == `SRC_SW || c.src == `SRC_SYNC)) begin
        cfg_ok = 1'b0;
      end
      if (c.rate == RATE_RSV) begin
        cfg_ok = 1'b0;
      end
    end
  endfunction

  always_comb begin
    base[0] = pick_base(s_q.fbase);
    base[1] = pick_base(s_q.tbase);
  end

  // Each divider picks which domain's base it divides
  genvar j;
  generate
    for (j = 0; j < 2; j = j + 1) begin : g_div
      logic [3:0] e1;
      assign e1 = s_q.dexp[j] - 4'h1;
      assign din[j] = base[s_q.dsrc[j]];
      // Bit n-1 of a rising-edge counter toggles every 2^(n-1) base cycles
      assign dout[j] = (s_q.dexp[j] == 4'h0) ? din[j] : s_q.dcnt[j][e1];
      assign clkv[j] = {1'b0, dout[1], dout[0], base[j]};
    end
  endgenerate

  // Slots 31 and 32 are replaced per route
  assign srcv = {front_clock_i, 1'b0, 1'b0, star_i, trig_i, front_i};

  genvar g;
  generate
    for (g = 0; g < ND; g = g + 1) begin : g_route
      localparam int DOM = (g < NF) ? 0 : 1;
      route_cfg_t c;
      logic ck;
      logic cp;
      logic fire;
      logic raw;
      assign c = s_q.route[g];
      assign ck = clkv[DOM][c.rate];
      assign cp = s_q.cprev[DOM][c.rate];
      assign edge_w[g] = c.fall ? (cp & ~ck) : (~cp & ck);
      assign fire = s_q.pend[g] & (s_q.cnt[g] == 4'h0);
      always_comb begin
        if (c.src == `SRC_SW) begin
          raw = fire;
        end else if (c.src == `SRC_SYNC) begin
          raw = ck;
        end else if (c.src < 6'(`SRC_W)) begin
          raw = srcv[c.src];
        end else begin
          raw = 1'b0;
        end
      end
      assign sv_w[g] = raw;
      always_comb begin
        if (!c.en) begin
          dst[g] = 1'b0;
        end else if (!c.sync) begin
          dst[g] = raw;
        end else if (c.src == `SRC_SYNC) begin
          dst[g] = ck ^ c.inv;
        end else begin
          dst[g] = s_q.q[g] ^ c.inv;
        end
      end
      assign dst_oe[g] = c.en;
    end
  endgenerate

  assign front_o = dst[NF-1:0];
  assign front_oe_o = dst_oe[NF-1:0];
  assign trig_o = dst[NF+NT-1:NF];
  assign trig_oe_o = dst_oe[NF+NT-1:NF];
  assign star_o = dst[ND-1:NF+NT];
  assign star_oe_o = dst_oe[ND-1:NF+NT];
  assign term_en_o = s_q.term;
  assign threshold_o = s_q.thr;
  assign wb_o.ack = s_q.ack;
  assign wb_o.dat = s_q.dat;

  assign widx = 6'(wb_i.adr[7:2] - `OFF_ROUTE0 / 4);

  // Read view of the addressed word
  always_comb begin
    rd = 32'h0000_0000;
    case (wb_i.adr[7:2])
      6'(`OFF_CTRL / 4): rd = {26'h000_0000, s_q.dsrc, s_q.tbase, s_q.fbase};
      6'(`OFF_DIV / 4): rd = {20'h0_0000, s_q.dexp[1], 4'h0, s_q.dexp[0]};
      6'(`OFF_STATUS / 4): rd = {30'h0000_0000, |s_q.pend, s_q.reject};
      6'(`OFF_TERM / 4): rd = {26'h000_0000, s_q.term};
      default: begin
        if (wb_i.adr >= `OFF_THR0 && wb_i.adr < `OFF_THR0 + 8'(4 * NF)) begin
          rd = 32'(s_q.thr[3'(wb_i.adr[4:2])]);
        end else if (wb_i.adr >= `OFF_ROUTE0 && widx < 6'(ND)) begin
          rd = {16'h0000, s_q.route[5'(widx)]};
        end
      end
    endcase
  end

  assign bmask = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}}, {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
  assign wv = (rd & ~bmask) | (wb_i.dat & bmask);

  always_comb begin
    logic wr;
    route_cfg_t nc;
    wr = 1'b0;
    nc = '0;
    s_d = s_q;
    // Answer one cycle after the request; drop ack the cycle after
    s_d.ack = wb_i.cyc & wb_i.stb & ~s_q.ack;
    if (wb_i.cyc && wb_i.stb && !s_q.ack) begin
      s_d.dat = rd;
    end
    wr = wb_i.cyc & wb_i.stb & wb_i.we & s_q.ack;

    for (int k = 0; k < 2; k++) begin
      if (!s_q.dprev[k] && din[k]) begin
        s_d.dcnt[k] = s_q.dcnt[k] + 9'h001;
      end
      s_d.dprev[k] = din[k];
      s_d.cprev[k] = clkv[k];
    end

    for (int i = 0; i < ND; i++) begin
      if (edge_w[i]) begin
        s_d.q[i] = sv_w[i];
        if (s_q.pend[i]) begin
          if (s_q.cnt[i] == 4'h0) begin
            s_d.pend[i] = 1'b0;
          end else begin
            s_d.cnt[i] = s_q.cnt[i] - 4'h1;
          end
        end
      end
    end

    if (wr) begin
      case (wb_i.adr[7:2])
        6'(`OFF_CTRL / 4): begin
          s_d.fbase = base_sel_t'(wv[1:0]);
          s_d.tbase = base_sel_t'(wv[3:2]);
          s_d.dsrc = wv[5:4];
        end
        6'(`OFF_DIV / 4): begin
          for (int k = 0; k < 2; k++) begin
            // Exponents above nine clamp to the 512 ratio
            s_d.dexp[k] = (wv[8*k+:4] > `EXP_MAX) ? `EXP_MAX : wv[8*k+:4];
            s_d.dcnt[k] = 9'h000;
          end
        end
        6'(`OFF_SWTRIG / 4): begin
          if (wv[0]) begin
            for (int i = 0; i < ND; i++) begin
              if (s_q.route[i].en && s_q.route[i].sync && s_q.route[i].src == `SRC_SW) begin
                s_d.pend[i] = 1'b1;
                s_d.cnt[i] = s_q.route[i].delay;
              end
            end
          end
        end
        6'(`OFF_STATUS / 4): begin
          if (wv[0]) begin
            s_d.reject = 1'b0;
          end
        end
        6'(`OFF_TERM / 4): s_d.term = wv[NF-1:0];
        default: begin
          if (wb_i.adr >= `OFF_THR0 && wb_i.adr < `OFF_THR0 + 8'(4 * NF)) begin
            s_d.thr[3'(wb_i.adr[4:2])] = wv[THR_W-1:0];
          end else if (wb_i.adr >= `OFF_ROUTE0 && widx < 6'(ND)) begin
            nc = route_cfg_t'(wv[15:0]);
            if (cfg_ok(widx, nc)) begin
              s_d.route[5'(widx)] = nc;
              // A rewritten route drops any pulse it still owed
              s_d.pend[5'(widx)] = 1'b0;
              s_d.q[5'(widx)] = 1'b0;
            end else begin
              s_d.reject = 1'b1;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= `RST_STATE;
    end else begin
      s_q <= s_d;
    end
  end

endmodule
`default_nettype wire

// ==== include/trm_consts.svh ====
// Register offsets, field codes and reset values of the trigger routing matrix
`ifndef TRM_CONSTS_SVH
`define TRM_CONSTS_SVH

`define N_FRONT 6
`define N_TRIG 8
`define N_STAR 17
`define N_DEST 31
`define THR_W_DEF 12

`define OFF_CTRL 8'h00
`define OFF_DIV 8'h04
`define OFF_SWTRIG 8'h08
`define OFF_STATUS 8'h0c
`define OFF_TERM 8'h10
`define OFF_THR0 8'h20
`define OFF_ROUTE0 8'h80

`define SRC_SW 6'h1f
`define SRC_SYNC 6'h20
`define SRC_FRONT_CLOCK_INPUT 6'h21
`define SRC_W 34

`define EXP_MAX 4'h9
`define RST_STATE '0

`endif

// ==== include/trm_pkg.sv ====
// Types shared by the trigger routing matrix and its bench
`default_nettype none
package trm_pkg;

  typedef enum logic [1:0] {
    BASE_SYNTH = 2'h0,
    BASE_CLK10 = 2'h1,
    BASE_FRONT0 = 2'h2,
    BASE_OFF = 2'h3
  } base_sel_t;

  typedef enum logic [1:0] {
    RATE_FULL = 2'h0,
    RATE_DIV1 = 2'h1,
    RATE_DIV2 = 2'h2,
    RATE_RSV = 2'h3
  } rate_t;

  typedef struct packed {
    logic [3:0] delay;
    rate_t rate;
    logic inv;
    logic fall;
    logic sync;
    logic en;
    logic [5:0] src;
  } route_cfg_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

endpackage
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench of the trigger routing matrix
`default_nettype none
module tb_top;
  timeunit 1ns / 1ps;
  import trm_pkg::*;
  logic clk_i = 0, rst_i = 1, pv;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  logic [15:0] cnt = '0, s = 16'h2373, v;
  logic [5:0] front_far = '0, front_l, front_o, front_oe_o, term_en_o;
  logic [7:0] trig_far = '0, trig_l, trig_o, trig_oe_o;
  logic [16:0] star_far = '0, star_l, star_o, star_oe_o;
  logic [71:0] threshold_o;
  logic [31:0] expq[$];
  logic [11:0] thr[6];
  logic [31:0] bad[5] = '{32'h0000_005f, 32'h0000_0060, 32'h0000_0061, 32'h0000_0062, 32'h0000_0cc0};
  int fail_count = 0, checks_done = 0, f1, f2, w1, w2, p;
  initial forever #4 clk_i = ~clk_i;
  // Base clocks as slow square waves sampled by clk_i
  always @(posedge clk_i) cnt <= cnt + 16'h0001;
  trigger_routing_matrix uut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(req), .wb_o(rsp), .pxi_clk10_i(cnt[3]),
    .synth_clk_i(cnt[1]), .front_clock_i(cnt[2]), .front_i(front_l), .front_o(front_o), .front_oe_o(front_oe_o),
    .trig_i(trig_l), .trig_o(trig_o), .trig_oe_o(trig_oe_o), .star_i(star_l), .star_o(star_o),
    .star_oe_o(star_oe_o), .term_en_o(term_en_o), .threshold_o(threshold_o));
  trm_line #(.W(6)) far_front (.oe_i(front_oe_o), .do_i(front_o), .far_i(front_far), .line_o(front_l));
  trm_line #(.W(8)) far_trig (.oe_i(trig_oe_o), .do_i(trig_o), .far_i(trig_far), .line_o(trig_l));
  trm_line #(.W(17)) far_star (.oe_i(star_oe_o), .do_i(star_o), .far_i(star_far), .line_o(star_l));
  function automatic logic [15:0] rnd();
    s = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    return s;
  endfunction
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", fail_count, checks_done);
    if (fail_count == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    // Ack is sampled at the rising edge that also applies the write
    do @(posedge clk_i); while (rsp.ack !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      fail_count++;
      conclude();
    end
    req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(1'b0, a, '0);
  endtask
  // Period of front line 3 in clk_i cycles, between its first two rises
  task automatic period(output int q);
    int t0;
    t0 = -1;
    q = 0;
    pv = 1'b1;
    for (int n = 0; n < 6000 && q == 0; n++) begin
      @(negedge clk_i);
      if (front_o[3] === 1'b1 && pv === 1'b0) begin
        if (t0 >= 0) q = n - t0;
        t0 = n;
      end
      pv = front_o[3];
    end
    if (q == 0) begin
      fail_count++;
      conclude();
    end
  endtask
  always @(posedge clk_i)
    if (rsp.ack === 1'b1 && req.we === 1'b0 && expq.size() > 0) cmp(rsp.dat, expq.pop_front());
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, '0);
    bus(1'b1, 8'h40, 32'h1234_5678);
    rd(8'h40, '0);
    bus(1'b1, 8'h10, 32'h0000_002a);
    rd(8'h10, 32'h0000_002a);
    cmp(term_en_o, 32'h0000_002a);
    for (int k = 0; k < 6; k++) begin
      v = rnd();
      thr[k] = v[11:0];
      bus(1'b1, 8'h20 + 8'(4 * k), {20'h0_0000, thr[k]});
    end
    // The last write lands at the edge the bus task returns on
    @(negedge clk_i);
    for (int k = 0; k < 6; k++) cmp(threshold_o[12*k+:12], thr[k]);
    // Asynchronous routes: trig 3 to front 0, star 4 to trig 0, front 2 out on star 5
    bus(1'b1, 8'h80, 32'h0000_0049);
    bus(1'b1, 8'h98, 32'h0000_0052);
    bus(1'b1, 8'hcc, 32'h0000_0042);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_i);
      v = rnd();
      trig_far <= v[7:0];
      star_far <= {v[0], v};
      front_far <= v[13:8];
      @(negedge clk_i);
      cmp({front_o[0], trig_o[0], star_l[5]}, {trig_l[3], star_l[4], front_l[2]});
      cmp({front_oe_o[0], trig_oe_o[0], star_oe_o[5]}, 3'h7);
    end
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 8'h84, bad[k]);
      rd(8'h84, '0);
      rd(8'h0c, 32'h0000_0001);
      bus(1'b1, 8'h0c, 32'h0000_0001);
      rd(8'h0c, '0);
    end
    // Software pulse: front 1 with delay 3, front 2 inverted with delay 0
    bus(1'b1, 8'h84, 32'h0000_30df);
    bus(1'b1, 8'h88, 32'h0000_02df);
    @(negedge clk_i);
    cmp(front_o[2:1], 2'h2);
    bus(1'b1, 8'h08, 32'h0000_0001);
    {f1, f2, w1, w2} = {-32'sd1, -32'sd1, 64'd0};
    for (int k = 0; k < 200; k++) begin
      @(negedge clk_i);
      if (front_o[1] === 1'b1 && f1 < 0) f1 = k;
      if (front_o[2] === 1'b0 && f2 < 0) f2 = k;
      w1 += int'(front_o[1] === 1'b1);
      w2 += int'(front_o[2] === 1'b0);
    end
    cmp(w1, 4);
    cmp(w2, 4);
    cmp(f1 - f2, 12);
    // Divided sync clock itself routed to front 3
    bus(1'b1, 8'h8c, 32'h0000_04e0);
    foreach (bad[k]) begin
      v = k == 0 ? 16'h0000 : k == 1 ? 16'h0002 : k == 2 ? 16'h0009 : 16'h000c;
      if (k < 4) begin
        bus(1'b1, 8'h04, {16'h0000, v});
        period(p);
        cmp(p, 4 << (v > 9 ? 9 : v));
      end
    end
    conclude();
  end
endmodule
`default_nettype wire

// ==== tb/trm_asserts.sv ====
// Port checker of the trigger routing matrix
`default_nettype none
module trm_asserts #(
  parameter int THR_W = 12
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire trm_pkg::wb_req_t wb_i,
  input wire trm_pkg::wb_rsp_t wb_o,
  input wire logic [5:0] front_o,
  input wire logic [5:0] front_oe_o,
  input wire logic [16:0] star_o,
  input wire logic [16:0] star_oe_o,
  input wire logic [7:0] trig_oe_o,
  input wire logic [5:0] term_en_o,
  input wire logic [6*THR_W-1:0] threshold_o
);
  import trm_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_i.cyc && wb_i.stb;
  wire wr = req && wb_i.we && wb_o.ack;
  ack_resp_a: assert property (req && !wb_o.ack |=> wb_o.ack) else $error("no ack");
  ack_pulse_a: assert property (wb_o.ack |=> !wb_o.ack) else $error("ack too long");
  unmapped_zero_a: assert property (wb_o.ack && !wb_i.we && wb_i.adr == 8'h40 |-> wb_o.dat == '0)
    else $error("unmapped data");
  term_write_a: assert property (wr && wb_i.adr == 8'h10 && wb_i.sel[0] |=> term_en_o == $past(wb_i.dat[5:0]))
    else $error("termination not written");
  thr_write_a: assert property (wr && wb_i.adr == 8'h20 && wb_i.sel == 4'hf |=>
    threshold_o[THR_W-1:0] == $past(wb_i.dat[THR_W-1:0])) else $error("threshold not written");
  reset_clear_a: assert property ($fell(rst_i) |-> front_oe_o == '0 && star_oe_o == '0 && trig_oe_o == '0)
    else $error("drive after reset");
  front_idle_a: assert property ((front_o & ~front_oe_o) == '0) else $error("front value undriven");
  star_idle_a: assert property ((star_o & ~star_oe_o) == '0) else $error("star value undriven");
  star_dir_a: assert property (!$stable(star_oe_o) |-> $past(wr)) else $error("star direction moved");
  cover property (wr && wb_i.adr == 8'h08);
  cover property (front_oe_o[1] && front_o[1]);
  cover property (star_oe_o[5] && star_o[5]);
endmodule
bind trigger_routing_matrix trm_asserts #(.THR_W(THR_W)) chk (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
  .wb_o(wb_o), .front_o(front_o), .front_oe_o(front_oe_o), .star_o(star_o), .star_oe_o(star_oe_o),
  .trig_oe_o(trig_oe_o), .term_en_o(term_en_o), .threshold_o(threshold_o));
`default_nettype wire

// ==== tb/trm_line.sv ====
// Far-end line model: a peer drives each line unless the matrix drives it
`default_nettype none
module trm_line #(
  parameter int W = 1
) (
  input wire logic [W-1:0] oe_i,
  input wire logic [W-1:0] do_i,
  input wire logic [W-1:0] far_i,
  output logic [W-1:0] line_o
);
  // Peer lets go where the matrix drives, so the wire shows one party only
  assign line_o = (oe_i & do_i) | (~oe_i & far_i);
endmodule
`default_nettype wire
